// ==== logic/xlc_pkg.sv ====
`default_nettype none
package xlc_pkg;
  localparam int XLC_LANES = 4;
  localparam int XLC_LAT_BITS = 72;
  localparam int XLC_RX_LAT_MIN = 84;
  localparam int XLC_RX_LAT_MAX = 225;
  localparam logic [3:0] XLC_REG_CTRL = 4'h0;
  localparam logic [3:0] XLC_REG_STATUS = 4'h4;
  localparam logic [3:0] XLC_REG_ERRCNT = 4'h8;
  localparam int XLC_CTRL_REINIT = 0;
  localparam int XLC_CTRL_FREEZE = 1;
  localparam int XLC_ST_ERR = 0;
  localparam int XLC_ST_TXRD = 4;
  localparam int XLC_ST_RXRD = 8;
  localparam int XLC_ST_CODEC = 12;
  localparam int XLC_ST_SYNC = 13;
  localparam logic XLC_FREEZE_RESET = 1'b0;
  localparam logic [3:0] XLC_RD_RESET = 4'h0;
  localparam logic [15:0] XLC_ERRCNT_RESET = 16'h0000;
  localparam logic [7:0] XLC_ERR_BYTE = 8'hFE;
  localparam int XLC_K_COUNT = 12;
  localparam int XLC_K28_7_IDX = 7;
  // Entries past the twelfth only pad the table to a power of two.
  localparam logic [7:0] XLC_K_BYTES [16] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC,
    8'hDC, 8'hFC, 8'hF7, 8'hFB, 8'hFD, 8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hFE};
  localparam logic [5:0] XLC_K28_6B = 6'h0F;
  localparam logic [3:0] XLC_ALT4 = 4'h7;
  localparam logic [9:0] XLC_BADK_NEG = 10'h0F0;
  localparam logic [9:0] XLC_BADK_POS = 10'h30F;
  localparam logic [9:0] XLC_K28_7_NEG = 10'h0F8;
  localparam logic [9:0] XLC_K28_7_POS = 10'h307;
  // Sub-block tables at negative disparity, first transmitted bit in the MSB.
  localparam logic [5:0] XLC_TAB6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19,
    6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13,
    6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] XLC_TAB4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  typedef struct packed {logic b9; logic k; logic [7:0] data;} xlc_word_type;
  typedef struct packed {logic rd; logic [9:0] code;} xlc_enc_type;
  typedef struct packed {logic rd; logic err; logic k; logic [7:0] data;} xlc_dec_type;
  typedef enum logic [0:0] {XLC_AV_IDLE = 1'b0, XLC_AV_ACK = 1'b1} xlc_av_state_type;
  function automatic logic [9:0] xlc_rev10(input logic [9:0] v);
    for (int i = 0; i < 10; i++) v = {v[8:0], v[9]} ^ 10'h000;
    return {<<{v}};
  endfunction
  function automatic logic xlc_k_valid(input logic [7:0] b);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < XLC_K_COUNT; i++) hit = hit | (XLC_K_BYTES[i] == b);
    return hit;
  endfunction
  // Encodes one byte; rd is 1 for positive running disparity.
  function automatic xlc_enc_type xlc_encode(input logic [7:0] b, input logic k, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic rd1;
    logic alt;
    logic [4:0] x;
    xlc_enc_type r;
    x = b[4:0];
    s6 = (k && x == 5'h1C) ? XLC_K28_6B : XLC_TAB6[x];
    rd1 = ($countones(s6) != 3) ? ~rd : rd;
    if (rd && ($countones(s6) != 3 || s6 == XLC_TAB6[7])) s6 = ~s6;
    alt = (b[7:5] == 3'h7) && (k || (rd1 ? (x == 5'h0B || x == 5'h0D || x == 5'h0E)
                                         : (x == 5'h11 || x == 5'h12 || x == 5'h14)));
    s4 = alt ? XLC_ALT4 : XLC_TAB4[b[7:5]];
    r.rd = ($countones(s4) != 2) ? ~rd1 : rd1;
    if (rd1 && ($countones(s4) != 2 || s4 == XLC_TAB4[3])) s4 = ~s4;
    // Balanced K28 sub-blocks take the opposite polarity from the data table when the 6-bit part leaves disparity negative.
    if (k && x == 5'h1C && !rd1 && $countones(s4) == 2 && s4 != XLC_TAB4[3]) s4 = ~s4;
    r.code = {s6, s4};
    // A bad control byte becomes an unbalanced word with an illegal 4-bit part; disparity is kept.
    if (k && !xlc_k_valid(b)) begin
      r.code = rd ? XLC_BADK_POS : XLC_BADK_NEG;
      r.rd = rd;
    end
    return r;
  endfunction
  // Decodes by matching against every legal word at the current disparity.
  function automatic xlc_dec_type xlc_decode(input logic [9:0] c, input logic rd);
    xlc_dec_type r;
    xlc_enc_type e;
    logic [7:0] cand;
    logic kc;
    r.data = XLC_ERR_BYTE;
    r.k = 1'b1;
    r.err = 1'b1;
    r.rd = ($countones(c) > 5) ? 1'b1 : (($countones(c) < 5) ? 1'b0 : rd);
    for (int j = 0; j < 256 + XLC_K_COUNT; j++) begin
      kc = (j > 255);
      cand = kc ? XLC_K_BYTES[j[3:0]] : j[7:0];
      e = xlc_encode(cand, kc, rd);
      if (r.err && e.code == c) begin
        r = {e.rd, 1'b0, kc, cand};
      end
    end
    return r;
  endfunction
endpackage
`default_nettype wire

// ==== logic/xlc_codec.sv ====
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RL1) Receive word updates on both selected-clock edges.
// (RL2) Sync select high: lane A clock; else own.
// (RL3) Shared mode: lane B-D clock outputs follow A.
// (RL4) Serial-to-parallel latency 84 to 225 bits.
// (RL5) Earliest received serial bit lands on bit 0.
// (RL6) Codec enable turns coding on, all lanes.
// (RL7) Encoder picks disparity keeping stream balanced.
// (RL8) Transmit bit 8 high sends a K-character.
// (RL9) Receive bit 8 high marks decoded K-character.
// (RL10) Exactly twelve K-characters, both disparities supported.
// (RL11) Unknown control byte sends an invalid character.
// (RL12) K28.7 byte and code words as tabulated.
// (RL13) Only K28.1, K28.5, K28.7 contain commas.
// (RL14) Host sends sequence code only on lane A.
// (RL15) Host sends start code only on lane A.
// (RL16) Lane A..D bytes map to data low..high.
// (RL17) Lane control bits map to control 0..3.
// (RL18) Decode error: K-flag, bit 9, byte FE.
// (RL19) Codec disabled: ten-bit words pass unchanged.
// (RL20) Transmit bit 9 ignored while encoding.
// (RL21) Running disparity starts negative after reset.
module xlc_codec
  import xlc_pkg::*;
#(
  parameter int LAT_BITS = XLC_LAT_BITS
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic CODEC_ENABLE,
  input wire logic LANE_SYNC_SELECT,
  input wire logic TX_STROBE,
  input wire xlc_word_type [3:0] TX_WORD,
  output logic [3:0][9:0] TX_CODE,
  output logic TX_CODE_VALID,
  input wire logic [3:0] RX_SERIAL,
  input wire logic [3:0] RX_CLK,
  output xlc_word_type [3:0] RX_WORD,
  output logic [3:0] RX_CLK_OUT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  logic [9:0] pin_s1_r;
  logic [9:0] pin_s2_r;
  logic [3:0] rclk_d_r;
  logic codec_q;
  logic sync_q;
  logic [3:0] ser_q;
  logic [3:0] rclk_q;
  logic [3:0] sel_clk;
  logic [3:0] sel_edge;
  xlc_av_state_type av_state_r;
  logic [31:0] rdata_nxt;
  logic wr_ack;
  logic reinit_p;
  logic freeze_r;
  logic [3:0] err_sticky_r;
  logic [15:0] errcnt_r;
  logic [3:0] tx_rd_r;
  logic [3:0][9:0] tx_code_r;
  xlc_enc_type tx_enc [4];
  logic [LAT_BITS-1:0] dly_r [4];
  logic [9:0] sh_r [4];
  logic [3:0] cnt_r [4];
  logic [9:0] word_r [4];
  logic [3:0] word_v_r;
  xlc_dec_type dec [4];
  xlc_word_type [3:0] dec_word_r;
  xlc_word_type [3:0] rx_out_r;
  logic [3:0] rx_rd_r;
  logic [3:0] lane_err_r;

  // Every pin from outside the clock domain passes two flops first.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_s1_r <= 10'h000;
      pin_s2_r <= 10'h000;
      rclk_d_r <= 4'h0;
    end else begin
      pin_s1_r <= {CODEC_ENABLE, LANE_SYNC_SELECT, RX_SERIAL, RX_CLK};
      pin_s2_r <= pin_s1_r;
      rclk_d_r <= pin_s2_r[3:0];
    end
  end

  assign codec_q = pin_s2_r[9];
  assign sync_q = pin_s2_r[8];
  assign ser_q = pin_s2_r[7:4];
  assign rclk_q = pin_s2_r[3:0];

  // Each lane watches its own recovered clock, or lane A's in shared mode.
  always_comb begin
    for (int i = 0; i < XLC_LANES; i++) begin
      sel_clk[i] = sync_q ? rclk_q[0] : rclk_q[i]; // RL2
      sel_edge[i] = sel_clk[i] ^ (sync_q ? rclk_d_r[0] : rclk_d_r[i]); // RL1
    end
  end

  // Avalon slave: one wait cycle, then a single cycle with waitrequest low.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      av_state_r <= XLC_AV_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      case (av_state_r)
        XLC_AV_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            av_state_r <= XLC_AV_ACK;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA <= AVS_READ ? rdata_nxt : 32'h0000_0000;
          end
        end
        default: begin
          av_state_r <= XLC_AV_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  assign wr_ack = (av_state_r == XLC_AV_ACK) && AVS_WRITE;
  assign reinit_p = wr_ack && AVS_ADDRESS == XLC_REG_CTRL && AVS_BYTEENABLE[0] &&
                    AVS_WRITEDATA[XLC_CTRL_REINIT];

  // Read mux; unmapped offsets read as zero.
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (AVS_ADDRESS == XLC_REG_CTRL) begin
      rdata_nxt[XLC_CTRL_FREEZE] = freeze_r;
    end else if (AVS_ADDRESS == XLC_REG_STATUS) begin
      rdata_nxt[XLC_ST_ERR +: 4] = err_sticky_r;
      rdata_nxt[XLC_ST_TXRD +: 4] = tx_rd_r;
      rdata_nxt[XLC_ST_RXRD +: 4] = rx_rd_r;
      rdata_nxt[XLC_ST_CODEC] = codec_q;
      rdata_nxt[XLC_ST_SYNC] = sync_q;
    end else if (AVS_ADDRESS == XLC_REG_ERRCNT) begin
      rdata_nxt[15:0] = errcnt_r;
    end
  end

  // Error bookkeeping; a new error outweighs a clear in the same cycle.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      freeze_r <= XLC_FREEZE_RESET;
      err_sticky_r <= 4'h0;
      errcnt_r <= XLC_ERRCNT_RESET;
    end else begin
      if (wr_ack && AVS_ADDRESS == XLC_REG_CTRL && AVS_BYTEENABLE[0]) begin
        freeze_r <= AVS_WRITEDATA[XLC_CTRL_FREEZE];
      end
      if (wr_ack && AVS_ADDRESS == XLC_REG_STATUS && AVS_BYTEENABLE[0]) begin
        err_sticky_r <= (err_sticky_r & ~AVS_WRITEDATA[XLC_ST_ERR +: 4]) | lane_err_r;
      end else begin
        err_sticky_r <= err_sticky_r | lane_err_r;
      end
      if (wr_ack && AVS_ADDRESS == XLC_REG_ERRCNT && AVS_BYTEENABLE[0]) begin
        errcnt_r <= 16'($countones(lane_err_r));
      end else if (!freeze_r && errcnt_r != 16'hFFFF) begin
        errcnt_r <= errcnt_r + 16'($countones(lane_err_r));
      end
    end
  end

  // Encoder per lane; bit 9 of the host word never reaches it.
  always_comb begin
    for (int i = 0; i < XLC_LANES; i++) begin
      tx_enc[i] = xlc_encode(TX_WORD[i].data, TX_WORD[i].k, tx_rd_r[i]); // RL6 RL7 RL8 RL20
    end
  end

  // Lane i of the word array is data byte i and control bit i.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_rd_r <= XLC_RD_RESET; // RL21
      tx_code_r <= '0;
      TX_CODE_VALID <= 1'b0;
    end else begin
      TX_CODE_VALID <= TX_STROBE;
      for (int i = 0; i < XLC_LANES; i++) begin
        if (TX_STROBE) begin
          if (codec_q) begin
            tx_code_r[i] <= xlc_rev10(tx_enc[i].code); // RL10 RL11 RL12 RL13 RL16 RL17
            tx_rd_r[i] <= tx_enc[i].rd;
          end else begin
            tx_code_r[i] <= TX_WORD[i]; // RL19
          end
        end
        if (reinit_p) begin
          tx_rd_r[i] <= 1'b0; // RL21
        end
      end
    end
  end

  assign TX_CODE = tx_code_r;

  // Fixed bit delay and deserializer; the oldest bit shifts down to bit 0.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < XLC_LANES; i++) begin
        dly_r[i] <= '0;
        sh_r[i] <= 10'h000;
        cnt_r[i] <= 4'h0;
        word_r[i] <= 10'h000;
      end
      word_v_r <= 4'h0;
    end else begin
      for (int i = 0; i < XLC_LANES; i++) begin
        dly_r[i] <= {ser_q[i], dly_r[i][LAT_BITS-1:1]}; // RL4
        sh_r[i] <= {dly_r[i][0], sh_r[i][9:1]}; // RL5
        cnt_r[i] <= (cnt_r[i] == 4'h9) ? 4'h0 : cnt_r[i] + 4'h1;
        word_v_r[i] <= (cnt_r[i] == 4'h9);
        if (cnt_r[i] == 4'h9) begin
          word_r[i] <= {dly_r[i][0], sh_r[i][9:1]};
        end
      end
    end
  end

  // Decoder per lane, against the lane's receive running disparity.
  always_comb begin
    for (int i = 0; i < XLC_LANES; i++) begin
      dec[i] = xlc_decode(xlc_rev10(word_r[i]), rx_rd_r[i]); // RL9 RL10 RL18
    end
  end

  // Decoded or raw word, disparity tracking and error pulses.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      dec_word_r <= '0;
      rx_rd_r <= XLC_RD_RESET;
      lane_err_r <= 4'h0;
    end else begin
      for (int i = 0; i < XLC_LANES; i++) begin
        lane_err_r[i] <= word_v_r[i] && codec_q && dec[i].err;
        if (word_v_r[i]) begin
          if (codec_q) begin
            dec_word_r[i] <= {dec[i].err, dec[i].k, dec[i].data}; // RL18
            rx_rd_r[i] <= dec[i].rd;
          end else begin
            dec_word_r[i] <= word_r[i]; // RL19
          end
        end
        if (reinit_p) begin
          rx_rd_r[i] <= 1'b0;
        end
      end
    end
  end

  // Output stage: words and clock outputs move only on selected edges.
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_out_r <= '0;
      RX_CLK_OUT <= 4'h0;
    end else begin
      RX_CLK_OUT <= sel_clk; // RL3
      for (int i = 0; i < XLC_LANES; i++) begin
        if (sel_edge[i]) begin
          rx_out_r[i] <= dec_word_r[i]; // RL1
        end
      end
    end
  end

  assign RX_WORD = rx_out_r;

  // Per-lane checks on timing and coding.
  for (genvar g = 0; g < XLC_LANES; g++) begin : g_chk
    a_rx_edge_only: assert property (!sel_edge[g] |=> $stable(rx_out_r[g])) // RL1
      else $error("receive word changed without a clock edge");
    a_sync_ref_a: assert property ((sync_q && rclk_q[0] == rclk_d_r[0]) |=> // RL2
      $stable(rx_out_r[g])) else $error("shared mode lane moved off lane A clock");
    a_sync_clk_out: assert property ((sync_q && $past(sync_q)) |=> // RL3
      RX_CLK_OUT[g] == RX_CLK_OUT[0]) else $error("clock output not following lane A");
    a_tx_bypass_raw: assert property ((TX_STROBE && !codec_q) |=> // RL19
      tx_code_r[g] == $past(TX_WORD[g])) else $error("bypass word altered");
    a_tx_rd_balance: assert property ((TX_STROBE && codec_q && !tx_rd_r[g] && // RL7
      !(TX_WORD[g].k && !xlc_k_valid(TX_WORD[g].data))) |=> $countones(tx_code_r[g]) >= 5)
      else $error("too few ones at negative disparity");
  end

  a_k28_7_word: assert property ((TX_STROBE && codec_q && TX_WORD[0].k && // RL12
    TX_WORD[0].data == XLC_K_BYTES[XLC_K28_7_IDX]) |=> tx_code_r[0] ==
    xlc_rev10($past(tx_rd_r[0]) ? XLC_K28_7_POS : XLC_K28_7_NEG))
    else $error("wrong code word for K28.7");
  a_bad_k_sent: assert property ((TX_STROBE && codec_q && TX_WORD[0].k && // RL11
    !xlc_k_valid(TX_WORD[0].data)) |=> tx_code_r[0][9:6] inside {4'h0, 4'hF})
    else $error("bad control byte not sent as invalid word");
  a_rx_err_byte: assert property ((word_v_r[0] && codec_q && dec[0].err) |=> // RL18
    dec_word_r[0] == {1'b1, 1'b1, XLC_ERR_BYTE}) else $error("error word not FE");
  a_rx_k_legal: assert property ((word_v_r[0] && codec_q && dec[0].k && !dec[0].err) // RL9
    |=> xlc_k_valid(dec_word_r[0].data)) else $error("flagged K byte not legal");
  a_rd_reinit: assert property (reinit_p |=> (tx_rd_r == 4'h0 && rx_rd_r == 4'h0)) // RL21
    else $error("disparity not negative after reinit");
  a_sticky_set: assert property (lane_err_r[0] |=> err_sticky_r[0])
    else $error("lane error lost");
  a_av_answer: assert property (((AVS_READ || AVS_WRITE) && av_state_r == XLC_AV_IDLE)
    |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST) else $error("bus answer timing");

  c_tx_k_char: cover property (TX_STROBE && codec_q && TX_WORD[0].k);
  c_rx_error: cover property (lane_err_r[0]);
  c_sync_edge: cover property (sync_q && sel_edge[1]);
  c_av_write: cover property (wr_ack);
endmodule
`default_nettype wire

// ==== verif/xlc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host MAC on the parallel side, plus the far link feeding the serial pins.
module xlc_mac_model
  import xlc_pkg::*;
(
  input wire logic mclk,
  input wire logic [9:0] link_word,
  output logic tx_strobe,
  output xlc_word_type [3:0] tx_word,
  output logic [3:0] rx_serial,
  output var logic [3:0] rx_clk,
  output logic wstart
);
  logic [9:0] sh = 10'h000;
  logic [3:0] pos = 4'h0;
  logic hold = 1'b0;
  initial begin
    tx_strobe = 1'b0;
    tx_word = '0;
  end
  // Recovered clocks run free, each lane a little later than the last.
  for (genvar i = 0; i < 4; i++) begin : g_clk
    initial begin
      rx_clk[i] = 1'b0;
      #(3 + 10 * i);
      forever #40 rx_clk[i] = ~rx_clk[i];
    end
  end
  // One serial bit per cycle, earliest bit from bit 0 of the word.
  always_ff @(posedge mclk) begin
    if (!hold) begin
      pos <= (pos == 4'h9) ? 4'h0 : pos + 4'h1;
      sh <= (pos == 4'h9) ? link_word : sh >> 1;
    end
  end
  assign rx_serial = {4{sh[0]}};
  assign wstart = (pos == 4'h0) && !hold;
  // Repeats the current bit so that later word boundaries move by d bits.
  task automatic slip(input int d);
    repeat (d) begin
      @(posedge mclk);
      hold <= 1'b1;
    end
    @(posedge mclk);
    hold <= 1'b0;
  endtask
  // One four-lane transfer; ordering codes are kept off lanes B to D.
  task automatic send(input xlc_word_type [3:0] w);
    for (int l = 1; l < 4; l++) begin
      if (w[l].k && (w[l].data == 8'h9C || w[l].data == 8'hFB)) begin
        w[l].data = 8'hFC;
      end
    end
    @(posedge mclk);
    tx_word <= w;
    tx_strobe <= 1'b1;
    @(posedge mclk);
    tx_strobe <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import xlc_pkg::*;
  logic MCLK;
  logic RSTN = 1'b0;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic CODEC_ENABLE = 1'b1;
  logic LANE_SYNC_SELECT = 1'b1;
  logic TX_STROBE;
  xlc_word_type [3:0] TX_WORD;
  logic [3:0][9:0] TX_CODE;
  logic TX_CODE_VALID;
  logic [3:0] RX_SERIAL;
  logic [3:0] RX_CLK;
  xlc_word_type [3:0] RX_WORD;
  logic [3:0] RX_CLK_OUT;
  logic [9:0] link_word = 10'h000;
  logic wstart;
  int err_count = 0;
  int checks_done = 0;
  int ndiff = 0;
  logic [31:0] q;
  // Control bytes and their code words at negative disparity, first bit leftmost.
  logic [7:0] kb [12] = '{8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
    8'hF7, 8'hFB, 8'hFD, 8'hFE};
  logic [9:0] kc [12] = '{10'h0F4, 10'h0F9, 10'h0F5, 10'h0F3, 10'h0F2, 10'h0FA,
    10'h0F6, 10'h0F8, 10'h3A8, 10'h368, 10'h2E8, 10'h1E8};
  // Receive test words, first bit leftmost, and the decoded words they should give.
  logic [9:0] rc [3] = '{10'h0F4, 10'h3A8, 10'h000};
  logic [9:0] re [3] = '{10'h11C, 10'h1F7, 10'h3FE};
  xlc_codec i_xlc_codec (.MCLK(MCLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CODEC_ENABLE(CODEC_ENABLE), .LANE_SYNC_SELECT(LANE_SYNC_SELECT),
    .TX_STROBE(TX_STROBE), .TX_WORD(TX_WORD), .TX_CODE(TX_CODE),
    .TX_CODE_VALID(TX_CODE_VALID), .RX_SERIAL(RX_SERIAL), .RX_CLK(RX_CLK),
    .RX_WORD(RX_WORD), .RX_CLK_OUT(RX_CLK_OUT));
  xlc_mac_model i_xlc_mac_model (.mclk(MCLK), .link_word(link_word), .tx_strobe(TX_STROBE),
    .tx_word(TX_WORD), .rx_serial(RX_SERIAL), .rx_clk(RX_CLK), .wstart(wstart));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  function automatic logic [9:0] rev(input logic [9:0] v);
    for (int i = 0; i < 10; i++) rev[i] = v[9 - i];
  endfunction
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One Avalon access; the request stands until waitrequest is seen low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge MCLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
    if (AVS_WAITREQUEST !== 1'b0) begin
      err_count++;
      report_and_stop;
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  // Waits n cycles, counting cycles where the lane clock outputs disagree.
  task idle(input int n);
    repeat (n) begin
      @(negedge MCLK);
      if (RX_CLK_OUT[3:1] !== {3{RX_CLK_OUT[0]}}) ndiff++;
    end
  endtask
  // Main sequence: reset, registers, transmit coding, bypass, receive path.
  initial begin
    xlc_word_type [3:0] w;
    logic [3:0] rd;
    logic [9:0] e [4];
    logic [9:0] c;
    int idx;
    int lat;
    int k;
    repeat (12) @(posedge MCLK);
    chk("wait_rst", AVS_WAITREQUEST, 1'b1);
    chk("code_rst", TX_CODE, 40'h0);
    RSTN <= 1'b1;
    repeat (3) @(posedge MCLK);
    bus(1'b0, XLC_REG_STATUS, 32'h0);
    chk("pins", q[13:12], 2'h3);
    bus(1'b1, XLC_REG_CTRL, 32'h2);
    bus(1'b0, XLC_REG_CTRL, 32'h0);
    chk("freeze", q, 32'h2);
    bus(1'b1, XLC_REG_CTRL, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk("unmapped", q, 32'h0);
    $display("test registers done");
    rd = 4'h0;
    for (int i = 0; i < 13; i++) begin
      for (int l = 0; l < 4; l++) begin
        idx = (i + l) % 12;
        if (l > 0 && (idx == 4 || idx == 9)) idx = 7;
        w[l] = {1'b1, 1'b1, (i == 12) ? 8'h07 : kb[idx]};
        e[l] = (i == 12) ? 10'h0F0 : kc[idx];
      end
      i_xlc_mac_model.send(w);
      @(negedge MCLK);
      chk("tx_valid", TX_CODE_VALID, 1'b1);
      for (int l = 0; l < 4; l++) begin
        c = rd[l] ? ~e[l] : e[l];
        chk("tx_code", TX_CODE[l], rev(c));
        if (i < 12) rd[l] = rd[l] ^ ($countones(c) != 5);
      end
    end
    $display("test encode done");
    @(posedge MCLK);
    CODEC_ENABLE <= 1'b0;
    repeat (3) @(posedge MCLK);
    w = {10'h155, 10'h2AA, 10'h3C1, 10'h00B};
    i_xlc_mac_model.send(w);
    @(negedge MCLK);
    chk("tx_bypass", TX_CODE, w);
    idle(250);
    @(posedge MCLK);
    link_word <= 10'h001;
    idle(150);
    c = RX_WORD[0];
    k = 0;
    for (int b = 0; b < 10; b++) if (c[b]) k = b;
    // Delay the stream so that the marker bit lands on the first bit of a word.
    i_xlc_mac_model.slip((10 - k) % 10);
    link_word <= 10'h00B;
    idle(250);
    for (int l = 0; l < 4; l++) chk("rx_raw", RX_WORD[l], 10'h00B);
    // Latency is taken on an aligned word, from its first bit at the pin.
    @(posedge MCLK);
    link_word <= 10'h000;
    idle(150);
    @(posedge MCLK);
    link_word <= 10'h001;
    @(posedge MCLK);
    k = 0;
    do begin
      @(negedge MCLK);
      k++;
    end while (!wstart && k < 20);
    chk("word_start", wstart, 1'b1);
    lat = 0;
    while (RX_WORD[0] === 10'h000 && lat < 400) begin
      @(negedge MCLK);
      lat++;
    end
    chk("latency", lat >= XLC_RX_LAT_MIN && lat <= XLC_RX_LAT_MAX, 1'b1);
    $display("test bypass done");
    @(posedge MCLK);
    CODEC_ENABLE <= 1'b1;
    repeat (3) @(posedge MCLK);
    bus(1'b1, XLC_REG_CTRL, 32'h1);
    ndiff = 0;
    for (int i = 0; i < 3; i++) begin
      @(posedge MCLK);
      link_word <= rev(rc[i]);
      idle(250);
      for (int l = 0; l < 4; l++) chk("rx_dec", RX_WORD[l], re[i]);
    end
    chk("clk_shared", ndiff, 64'h0);
    @(posedge MCLK);
    link_word <= rev(rc[0]);
    idle(250);
    bus(1'b0, XLC_REG_ERRCNT, 32'h0);
    chk("errcnt", q != 32'h0, 1'b1);
    bus(1'b1, XLC_REG_ERRCNT, 32'h0);
    bus(1'b0, XLC_REG_ERRCNT, 32'h0);
    chk("errcnt_clr", q, 32'h0);
    bus(1'b1, XLC_REG_STATUS, 32'hF);
    bus(1'b0, XLC_REG_STATUS, 32'h0);
    chk("sticky_clr", q[3:0], 4'h0);
    @(posedge MCLK);
    LANE_SYNC_SELECT <= 1'b0;
    ndiff = 0;
    idle(200);
    chk("clk_own", ndiff > 0, 1'b1);
    chk("rx_own", RX_WORD[3], 10'h11C);
    $display("test receive done");
    report_and_stop;
  end
endmodule
`default_nettype wire
